// File: logic/pwm_compare_consts.svh
// constants for the dual output modulator and compare block
// assumes one 100 MHz clock and word-aligned Avalon-MM register access
`ifndef PWM_COMPARE_CONSTS_SVH
`define PWM_COMPARE_CONSTS_SVH

// clock rate and duty scale
`define CLK_HZ_DEF        100000000
`define DUTY_FULL_SCALE   32000

// output mode codes, per output channel
`define MODE_NORMAL       2'h0
`define MODE_PWM          2'h1
`define MODE_COMPARE      2'h2

// register indices; byte address is four times the index
`define IDX_PRESET_ONE    5'h03
`define IDX_PRESET_TWO    5'h05
`define IDX_DUTY_ONE      5'h07
`define IDX_FREQ_ONE      5'h09
`define IDX_DUTY_TWO      5'h0b
`define IDX_FREQ_TWO      5'h0d
`define IDX_CONTROL       5'h10
`define IDX_STOP_DUTY_ONE 5'h11
`define IDX_STOP_FREQ_ONE 5'h12
`define IDX_STOP_DUTY_TWO 5'h13
`define IDX_STOP_FREQ_TWO 5'h14
`define IDX_CLEAR         5'h15
`define IDX_ACC_ONE       5'h18
`define IDX_ACC_TWO       5'h19
`define IDX_ACC_THREE     5'h1a
`define IDX_ACC_FOUR      5'h1b
`define IDX_STATUS        5'h1c

// control register fields
`define CTL_MODE_ONE      1:0
`define CTL_MODE_TWO      3:2
`define CTL_SW_ONE        4
`define CTL_SW_TWO        5
`define CTL_EN_ONE        6
`define CTL_EN_TWO        7
`define CTL_STOP          8
`define CTL_STOP_HOLD     9
`define CTL_WIDTH         10

// clear register fields, write one to pulse
`define CLR_COUNTER_ONE   0
`define CLR_COUNTER_THREE 1

// reset values
`define RESET_WORD        32'h00000000
`define RESET_CONTROL     10'h000

`endif

// File: logic/pwm_compare_pkg.sv
// shared types for the modulator and compare block
// assumes the constants header is included by each user
package pwm_compare_pkg;
   typedef logic [31:0] word_t;
   typedef enum logic {CH_IDLE, CH_RUN} chan_state_t;
endpackage : pwm_compare_pkg

// File: logic/pwm_chan_if.sv
// settings and result of one modulator channel
// assumes the top drives settings from its registers
`timescale 1ns/1ns
`default_nettype none
interface pwm_chan_if;
   import pwm_compare_pkg::*;
   word_t freq;
   word_t duty;
   word_t stopFreq;
   word_t stopDuty;
   logic  enable;
   logic  stopMode;
   logic  stopHold;
   logic  pwmOut;
   logic  active;
   modport ctrl (output freq, duty, stopFreq, stopDuty, enable, stopMode, stopHold,
                 input pwmOut, active);
   modport chan (input freq, duty, stopFreq, stopDuty, enable, stopMode, stopHold,
                 output pwmOut, active);
endinterface : pwm_chan_if
`default_nettype wire

// File: logic/pwm_channel.sv
// one pulse-width modulator channel driven by a phase accumulator
// assumes settings come through pwm_chan_if from the register file
`timescale 1ns/1ns
`default_nettype none
`include "pwm_compare_consts.svh"
module pwm_channel
   import pwm_compare_pkg::*;
#(
   parameter int unsigned CLK_HZ = `CLK_HZ_DEF
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   pwm_chan_if.chan  ch
);
   localparam logic [32:0] CLK33 = 33'(CLK_HZ);
   localparam logic [47:0] STEP  = 48'(CLK_HZ / `DUTY_FULL_SCALE);

   chan_state_t state_q, state_d;
   word_t       phase_q, phase_d;
   word_t       freqL_q, freqL_d;
   word_t       dutyL_q, dutyL_d;
   logic        out_q,   out_d;
   word_t       selFreq, selDuty, clampFreq;
   logic [32:0] sum;

   // high while the phase sits below duty times cycles per step
   function automatic logic highPhase(input word_t ph, input word_t dt);
      highPhase = {16'h0000, ph} < (48'(dt) * STEP); // [R6] [R7]
   endfunction : highPhase

   // phase accumulator wraps once per period of one over frequency
   always_comb begin
      selFreq   = (ch.stopMode) ? ch.stopFreq : ch.freq;   // [R10]
      selDuty   = (ch.stopMode) ? ch.stopDuty : ch.duty;   // [R10]
      // above the clock rate the period cannot shrink further
      clampFreq = ({1'b0, selFreq} > CLK33) ? CLK33[31:0] : selFreq;
      sum       = {1'b0, phase_q} + {1'b0, freqL_q};       // [R8]
      state_d   = state_q;
      phase_d   = phase_q;
      freqL_d   = freqL_q;
      dutyL_d   = dutyL_q;
      out_d     = out_q;
      if (ch.stopMode && ch.stopHold) begin
         out_d = out_q;                                    // [R10]
      end else if (!ch.enable || selFreq == `RESET_WORD || selDuty == `RESET_WORD) begin
         state_d = CH_IDLE;                                // [R5] [R9] [R11]
         phase_d = `RESET_WORD;
         out_d   = 1'b0;
      end else begin
         case (state_q)
            CH_IDLE: begin
               state_d = CH_RUN;
               phase_d = `RESET_WORD;
               freqL_d = clampFreq;
               dutyL_d = selDuty;
               out_d   = highPhase(`RESET_WORD, selDuty);
            end
            CH_RUN: begin
               if (sum >= CLK33) begin
                  // new settings only at the period boundary
                  phase_d = 32'(sum - CLK33);              // [R16]
                  freqL_d = clampFreq;                     // [R16]
                  dutyL_d = selDuty;                       // [R16]
                  out_d   = highPhase(32'(sum - CLK33), selDuty);
               end else begin
                  phase_d = sum[31:0];
                  out_d   = highPhase(sum[31:0], dutyL_q);
               end
            end
            default: begin
               state_d = CH_IDLE;
               out_d   = 1'b0;
            end
         endcase
      end
   end

   // channel state registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= CH_IDLE;
         phase_q <= `RESET_WORD;
         freqL_q <= `RESET_WORD;
         dutyL_q <= `RESET_WORD;
         out_q   <= 1'b0;                                  // [R9]
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         freqL_q <= freqL_d;
         dutyL_q <= dutyL_d;
         out_q   <= out_d;
      end
   end

   assign ch.pwmOut = out_q;
   assign ch.active = (state_q == CH_RUN);
endmodule : pwm_channel
`default_nettype wire

// File: logic/dual_output_pwm_compare.sv
// two dedicated outputs: software bit, modulator or counter compare
// assumes an Avalon-MM master on ref_clk; counters live outside
//
// Function
// R1: each output picks its own mode
// R2: normal mode follows software output bit
// R3: compare mode uses its own counter
// R4: presets held at index three and five
// R5: modulator channels have own enable, settings
// R6: duty 0..32000 is high fraction
// R7: duty zero low, full scale high
// R8: frequency in hertz, period its reciprocal
// R9: low until period and duty non-zero
// R10: stop mode holds or uses stop settings
// R11: zero stop setting keeps output low
// R12: channel one duty index 7, frequency 9
// R13: channel two duty index 11, frequency 13
// R14: clear bits zero counter one or three
// R15: compare high when count reaches preset
// R16: new settings at period boundary only
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_compare_consts.svh"
module dual_output_pwm_compare
   import pwm_compare_pkg::*;
#(
   parameter int unsigned CLK_HZ = `CLK_HZ_DEF
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [6:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic [31:0] counterOneCount,
   input  wire logic [31:0] counterTwoCount,
   input  wire logic [31:0] counterThreeCount,
   input  wire logic [31:0] counterFourCount,
   output logic             outputChannelOne,
   output logic             outputChannelTwo,
   output logic             counterOneClear,
   output logic             counterThreeClear
);
   pwm_chan_if chOne ();
   pwm_chan_if chTwo ();

   // software-visible registers
   word_t                   presetOne_q,   presetOne_d;
   word_t                   presetTwo_q,   presetTwo_d;
   word_t                   dutyOne_q,     dutyOne_d;
   word_t                   freqOne_q,     freqOne_d;
   word_t                   dutyTwo_q,     dutyTwo_d;
   word_t                   freqTwo_q,     freqTwo_d;
   word_t                   stopDutyOne_q, stopDutyOne_d;
   word_t                   stopFreqOne_q, stopFreqOne_d;
   word_t                   stopDutyTwo_q, stopDutyTwo_d;
   word_t                   stopFreqTwo_q, stopFreqTwo_d;
   logic [`CTL_WIDTH-1:0]   control_q,     control_d;

   // bus handshake and output registers
   logic                    wait_q,        wait_d;
   word_t                   rdata_q,       rdata_d;
   logic                    outOne_q,      outOne_d;
   logic                    outTwo_q,      outTwo_d;
   logic                    clrOne_q,      clrOne_d;
   logic                    clrThree_q,    clrThree_d;

   logic                    commit;
   logic [4:0]              regIdx;

   // keep the bytes that the master enables, the rest as they were
   function automatic word_t mergeBytes(input word_t old, input word_t wd,
                                        input logic [3:0] be);
      word_t res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      mergeBytes = res;
   endfunction : mergeBytes

   // one output's level for its configured mode
   function automatic logic pickOutput(input logic [1:0] mode, input logic swBit,
                                       input logic pwmBit, input word_t count,
                                       input word_t preset);
      case (mode)
         `MODE_NORMAL:  pickOutput = swBit;               // [R2]
         `MODE_PWM:     pickOutput = pwmBit;              // [R5]
         `MODE_COMPARE: pickOutput = (count >= preset);   // [R15]
         default:       pickOutput = 1'b0;
      endcase
   endfunction : pickOutput

   // readback mux; unmapped indices read as zero
   function automatic word_t readMux(input logic [4:0] idx);
      case (idx)
         `IDX_PRESET_ONE:    readMux = presetOne_q;
         `IDX_PRESET_TWO:    readMux = presetTwo_q;
         `IDX_DUTY_ONE:      readMux = dutyOne_q;
         `IDX_FREQ_ONE:      readMux = freqOne_q;
         `IDX_DUTY_TWO:      readMux = dutyTwo_q;
         `IDX_FREQ_TWO:      readMux = freqTwo_q;
         `IDX_CONTROL:       readMux = {22'h000000, control_q};
         `IDX_STOP_DUTY_ONE: readMux = stopDutyOne_q;
         `IDX_STOP_FREQ_ONE: readMux = stopFreqOne_q;
         `IDX_STOP_DUTY_TWO: readMux = stopDutyTwo_q;
         `IDX_STOP_FREQ_TWO: readMux = stopFreqTwo_q;
         `IDX_ACC_ONE:       readMux = counterOneCount;
         `IDX_ACC_TWO:       readMux = counterTwoCount;
         `IDX_ACC_THREE:     readMux = counterThreeCount;
         `IDX_ACC_FOUR:      readMux = counterFourCount;
         `IDX_STATUS:        readMux = {28'h0000000, chTwo.active, chOne.active,
                                        outTwo_q, outOne_q};
         default:            readMux = `RESET_WORD;
      endcase
   endfunction : readMux

   // byte address is four times the register index
   assign regIdx = address[6:2];
   // a request takes effect on the edge where waitrequest is seen low
   assign commit = (read || write) && !wait_q;

   // bus handshake: one wait cycle, then a single answer cycle
   always_comb begin
      wait_d  = 1'b1;
      rdata_d = rdata_q;
      if ((read || write) && wait_q) begin
         wait_d  = 1'b0;
         rdata_d = read ? readMux(regIdx) : `RESET_WORD;
      end
   end

   // register writes, applied at the commit edge only
   always_comb begin
      presetOne_d   = presetOne_q;
      presetTwo_d   = presetTwo_q;
      dutyOne_d     = dutyOne_q;
      freqOne_d     = freqOne_q;
      dutyTwo_d     = dutyTwo_q;
      freqTwo_d     = freqTwo_q;
      stopDutyOne_d = stopDutyOne_q;
      stopFreqOne_d = stopFreqOne_q;
      stopDutyTwo_d = stopDutyTwo_q;
      stopFreqTwo_d = stopFreqTwo_q;
      control_d     = control_q;
      clrOne_d      = 1'b0;
      clrThree_d    = 1'b0;
      if (commit && write) begin
         case (regIdx)
            `IDX_PRESET_ONE:    presetOne_d   = mergeBytes(presetOne_q, writedata, byteenable); // [R4]
            `IDX_PRESET_TWO:    presetTwo_d   = mergeBytes(presetTwo_q, writedata, byteenable); // [R4]
            `IDX_DUTY_ONE:      dutyOne_d     = mergeBytes(dutyOne_q, writedata, byteenable); // [R12]
            `IDX_FREQ_ONE:      freqOne_d     = mergeBytes(freqOne_q, writedata, byteenable); // [R12]
            `IDX_DUTY_TWO:      dutyTwo_d     = mergeBytes(dutyTwo_q, writedata, byteenable); // [R13]
            `IDX_FREQ_TWO:      freqTwo_d     = mergeBytes(freqTwo_q, writedata, byteenable); // [R13]
            `IDX_STOP_DUTY_ONE: stopDutyOne_d = mergeBytes(stopDutyOne_q, writedata, byteenable);
            `IDX_STOP_FREQ_ONE: stopFreqOne_d = mergeBytes(stopFreqOne_q, writedata, byteenable);
            `IDX_STOP_DUTY_TWO: stopDutyTwo_d = mergeBytes(stopDutyTwo_q, writedata, byteenable);
            `IDX_STOP_FREQ_TWO: stopFreqTwo_d = mergeBytes(stopFreqTwo_q, writedata, byteenable);
            `IDX_CONTROL: begin
               control_d = `CTL_WIDTH'(mergeBytes({22'h000000, control_q}, writedata,
                                      byteenable));
            end
            `IDX_CLEAR: begin
               // pulse only; no configuration needed for the clear
               clrOne_d   = byteenable[0] && writedata[`CLR_COUNTER_ONE];   // [R14]
               clrThree_d = byteenable[0] && writedata[`CLR_COUNTER_THREE]; // [R14]
            end
            default: begin
               control_d = control_q;
            end
         endcase
      end
   end

   // each output chooses its own source every cycle
   always_comb begin
      outOne_d = pickOutput(control_q[`CTL_MODE_ONE], control_q[`CTL_SW_ONE],
                            chOne.pwmOut, counterOneCount, presetOne_q);   // [R1] [R3]
      outTwo_d = pickOutput(control_q[`CTL_MODE_TWO], control_q[`CTL_SW_TWO],
                            chTwo.pwmOut, counterTwoCount, presetTwo_q);   // [R1] [R3]
   end

   // all state registers; settings clear at reset so outputs start low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         presetOne_q   <= `RESET_WORD;
         presetTwo_q   <= `RESET_WORD;
         dutyOne_q     <= `RESET_WORD;
         freqOne_q     <= `RESET_WORD;
         dutyTwo_q     <= `RESET_WORD;
         freqTwo_q     <= `RESET_WORD;
         stopDutyOne_q <= `RESET_WORD;
         stopFreqOne_q <= `RESET_WORD;
         stopDutyTwo_q <= `RESET_WORD;
         stopFreqTwo_q <= `RESET_WORD;
         control_q     <= `RESET_CONTROL;
         wait_q        <= 1'b1;
         rdata_q       <= `RESET_WORD;
         outOne_q      <= 1'b0;
         outTwo_q      <= 1'b0;
         clrOne_q      <= 1'b0;
         clrThree_q    <= 1'b0;
      end else begin
         presetOne_q   <= presetOne_d;
         presetTwo_q   <= presetTwo_d;
         dutyOne_q     <= dutyOne_d;
         freqOne_q     <= freqOne_d;
         dutyTwo_q     <= dutyTwo_d;
         freqTwo_q     <= freqTwo_d;
         stopDutyOne_q <= stopDutyOne_d;
         stopFreqOne_q <= stopFreqOne_d;
         stopDutyTwo_q <= stopDutyTwo_d;
         stopFreqTwo_q <= stopFreqTwo_d;
         control_q     <= control_d;
         wait_q        <= wait_d;
         rdata_q       <= rdata_d;
         outOne_q      <= outOne_d;
         outTwo_q      <= outTwo_d;
         clrOne_q      <= clrOne_d;
         clrThree_q    <= clrThree_d;
      end
   end

   // settings to modulator channel one
   assign chOne.freq     = freqOne_q;
   assign chOne.duty     = dutyOne_q;
   assign chOne.stopFreq = stopFreqOne_q;
   assign chOne.stopDuty = stopDutyOne_q;
   assign chOne.enable   = control_q[`CTL_EN_ONE];
   assign chOne.stopMode = control_q[`CTL_STOP];
   assign chOne.stopHold = control_q[`CTL_STOP_HOLD];

   // settings to modulator channel two
   assign chTwo.freq     = freqTwo_q;
   assign chTwo.duty     = dutyTwo_q;
   assign chTwo.stopFreq = stopFreqTwo_q;
   assign chTwo.stopDuty = stopDutyTwo_q;
   assign chTwo.enable   = control_q[`CTL_EN_TWO];
   assign chTwo.stopMode = control_q[`CTL_STOP];
   assign chTwo.stopHold = control_q[`CTL_STOP_HOLD];

   pwm_channel #(.CLK_HZ(CLK_HZ)) chanOne (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ch      (chOne.chan)
   );

   pwm_channel #(.CLK_HZ(CLK_HZ)) chanTwo (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ch      (chTwo.chan)
   );

   // ports straight from flip-flops
   assign readdata          = rdata_q;
   assign waitrequest       = wait_q;
   assign outputChannelOne  = outOne_q;
   assign outputChannelTwo  = outTwo_q;
   assign counterOneClear   = clrOne_q;
   assign counterThreeClear = clrThree_q;
endmodule : dual_output_pwm_compare
`default_nettype wire

// File: bench/pwm_compare_checker.sv
// port assertions for the dual output modulator and compare block
// assumes a bind onto dual_output_pwm_compare from the bench top file
`timescale 1ns/1ns
`default_nettype none
`include "pwm_compare_consts.svh"
module pwm_compare_checker #(
   parameter int unsigned CLK_HZ = `CLK_HZ_DEF
) (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [6:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic [31:0] counterOneCount,
   input wire logic        outputChannelOne,
   input wire logic        counterOneClear,
   input wire logic        counterThreeClear
);
   logic [31:0] ctl_q, ctl_d, pre_q, pre_d, duty_q, duty_d, freq_q, freq_d;
   logic [2:0]  age_q, age_d;
   logic        commit;
   logic [4:0]  idx;

   function automatic logic [31:0] upd(input logic [31:0] old, input logic hit,
                                       input logic [31:0] d, input logic [3:0] be);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < 4; i++) begin
         if (hit && be[i]) begin
            v[8*i +: 8] = d[8*i +: 8];
         end
      end
      return v;
   endfunction : upd

   // shadow settings; age counts edges since any write, so output lag is allowed for
   always_comb begin
      commit = write && !waitrequest;
      idx    = address[6:2];
      ctl_d  = rst ? 32'h0 : upd(ctl_q, commit && idx == `IDX_CONTROL, writedata, byteenable);
      pre_d  = rst ? 32'h0 : upd(pre_q, commit && idx == `IDX_PRESET_ONE, writedata, byteenable);
      duty_d = rst ? 32'h0 : upd(duty_q, commit && idx == `IDX_DUTY_ONE, writedata, byteenable);
      freq_d = rst ? 32'h0 : upd(freq_q, commit && idx == `IDX_FREQ_ONE, writedata, byteenable);
      age_d  = (rst || commit) ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
   end

   // register the shadows
   always_ff @(posedge ref_clk) begin
      ctl_q  <= ctl_d;
      pre_q  <= pre_d;
      duty_q <= duty_d;
      freq_q <= freq_d;
      age_q  <= age_d;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   chk_wait_answer:
      assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
   chk_wait_single:
      assert property (!waitrequest |=> waitrequest) else $error("wait low too long");
   chk_preset_read:
      assert property (read && !waitrequest && idx == `IDX_PRESET_ONE |-> readdata == pre_q)
         else $error("preset readback wrong");
   chk_clear_one:
      assert property (counterOneClear == $past(commit && idx == `IDX_CLEAR && byteenable[0]
         && writedata[`CLR_COUNTER_ONE])) else $error("clear one pulse wrong");
   chk_clear_three:
      assert property (counterThreeClear == $past(commit && idx == `IDX_CLEAR && byteenable[0]
         && writedata[`CLR_COUNTER_THREE])) else $error("clear three pulse wrong");
   chk_normal_follow:
      assert property (age_q >= 3'h2 && ctl_q[`CTL_MODE_ONE] == `MODE_NORMAL
         |-> outputChannelOne == ctl_q[`CTL_SW_ONE]) else $error("normal output wrong");
   chk_compare_level:
      assert property (age_q >= 3'h2 && ctl_q[`CTL_MODE_ONE] == `MODE_COMPARE
         |-> outputChannelOne == ($past(counterOneCount) >= pre_q)) else $error("compare wrong");
   chk_pwm_off:
      assert property (age_q >= 3'h4 && ctl_q[`CTL_MODE_ONE] == `MODE_PWM && !ctl_q[`CTL_STOP]
         && !ctl_q[`CTL_EN_ONE] |-> !outputChannelOne) else $error("disabled output high");
   chk_pwm_zero:
      assert property (age_q >= 3'h4 && ctl_q[`CTL_MODE_ONE] == `MODE_PWM && !ctl_q[`CTL_STOP]
         && (duty_q == 32'h0 || freq_q == 32'h0) |-> !outputChannelOne)
         else $error("unset modulator high");
endmodule : pwm_compare_checker
`default_nettype wire

// File: bench/load_model.sv
// load on one output pin: tallies high cycles and rising edges
// assumes the pin is sampled on the block clock
`timescale 1ns/1ns
`default_nettype none
module load_model (
   input  wire logic        ref_clk,
   input  wire logic        pinLevel,
   input  wire logic        clearStats,
   output logic      [31:0] highCycles,
   output logic      [31:0] rises
);
   logic lastLevel;
   // a sampling scope; glitches shorter than a cycle go unseen
   always_ff @(posedge ref_clk) begin
      lastLevel <= pinLevel;
      highCycles <= clearStats ? 32'h0 : highCycles + {31'h0, pinLevel};
      rises <= clearStats ? 32'h0 : rises + {31'h0, pinLevel && !lastLevel};
   end
endmodule : load_model
`default_nettype wire

// File: bench/dual_output_pwm_compare_tb.sv
// self-checking bench for the dual output modulator and compare block
// assumes design, header, load model and checker compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "pwm_compare_consts.svh"
`define CHECK(what, exp, got) begin checksDone++; if ((got) !== (exp)) begin errTotal++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module dual_output_pwm_compare_tb;
   import pwm_compare_pkg::*;
   logic       ref_clk, rst, read, write, waitrequest, clearStats;
   logic       outOne, outTwo, clrOne, clrThree;
   logic [6:0] address;
   logic [3:0] byteenable;
   word_t      writedata, readdata, rd, countOne, countTwo, countThree, countFour;
   word_t      hiOne, hiTwo, riOne, riTwo;
   int         errTotal, checksDone, clrOneSeen, clrThreeSeen;
   logic [6:0] regAddr [6] = '{7'h0c, 7'h14, 7'h1c, 7'h24, 7'h2c, 7'h34};
   word_t      regVal [6] = '{32'h64, 32'h32, 32'h1f40, 32'hf4240, 32'h3e80, 32'h1e8480};

   dual_output_pwm_compare uut (.ref_clk(ref_clk), .rst(rst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .counterOneCount(countOne),
      .counterTwoCount(countTwo), .counterThreeCount(countThree),
      .counterFourCount(countFour), .outputChannelOne(outOne), .outputChannelTwo(outTwo),
      .counterOneClear(clrOne), .counterThreeClear(clrThree));
   load_model loadOne (.ref_clk(ref_clk), .pinLevel(outOne), .clearStats(clearStats),
      .highCycles(hiOne), .rises(riOne));
   load_model loadTwo (.ref_clk(ref_clk), .pinLevel(outTwo), .clearStats(clearStats),
      .highCycles(hiTwo), .rises(riTwo));

   // high cycles and rises in a 1000-cycle window, a whole number of periods
   function automatic word_t expHigh(input word_t d, input word_t f, input logic edges);
      if (f == 32'h0 || d == 32'h0) return 32'h0;
      if (d >= `DUTY_FULL_SCALE) return edges ? 32'h0 : 32'h3e8;
      return edges ? 32'h3e8 * f / `CLK_HZ_DEF : 32'h3e8 * d / `DUTY_FULL_SCALE;
   endfunction : expHigh

   task automatic access(input logic wr, input logic [6:0] a, input word_t d);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      @(posedge ref_clk);
      while (waitrequest !== 1'b0) @(posedge ref_clk);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge ref_clk);
   endtask : access

   task automatic measure(input word_t d1, input word_t f1, input word_t d2, input word_t f2);
      repeat (300) @(posedge ref_clk);
      clearStats <= 1'b1;
      @(posedge ref_clk);
      clearStats <= 1'b0;
      repeat (1000) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHECK("high one", expHigh(d1, f1, 1'b0), hiOne)
      `CHECK("rises one", expHigh(d1, f1, 1'b1), riOne)
      `CHECK("high two", expHigh(d2, f2, 1'b0), hiTwo)
      `CHECK("rises two", expHigh(d2, f2, 1'b1), riTwo)
      @(posedge ref_clk);
   endtask : measure

   task automatic outs(input logic e1, input logic e2);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHECK("output one", e1, outOne)
      `CHECK("output two", e2, outTwo)
      @(posedge ref_clk);
   endtask : outs

   task automatic printVerdict;
      $display("mismatches %0d comparisons %0d", errTotal, checksDone);
      if (errTotal == 0 && checksDone > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : printVerdict

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // the counters stand outside; a clear-one pulse zeroes count one as a real one would, clear three is only tallied
   always @(posedge ref_clk) begin
      if (clrOne === 1'b1) begin
         clrOneSeen++;
         countOne <= 32'h0;
      end
      if (clrThree === 1'b1) clrThreeSeen++;
   end

   // watchdog at about five times the planned run
   initial begin
      repeat (40000) @(posedge ref_clk);
      errTotal++;
      printVerdict();
   end

   initial begin
      {rst, read, write, clearStats} = 4'h8;
      {address, writedata, byteenable} = {7'h0, 32'h0, 4'hf};
      {countOne, countTwo, countThree, countFour} = {32'h0, 32'h0, 32'habcd, 32'h12};
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      access(1'b0, 7'h40, 32'h0);
      `CHECK("control reset", 32'h0, rd)
      access(1'b1, 7'h40, 32'hc5);
      access(1'b1, 7'h1c, regVal[2]);
      measure(regVal[2], 32'h0, 32'h0, 32'h0);
      for (int i = 0; i < 6; i++) access(1'b1, regAddr[i], regVal[i]);
      for (int i = 0; i < 6; i++) begin
         access(1'b0, regAddr[i], 32'h0);
         `CHECK("setting readback", regVal[i], rd)
      end
      measure(regVal[2], regVal[3], regVal[4], regVal[5]);
      access(1'b1, 7'h1c, 32'h7d00);
      access(1'b1, 7'h2c, 32'h0);
      measure(32'h7d00, regVal[3], 32'h0, regVal[5]);
      access(1'b1, 7'h40, 32'h3c5); // stop, hold last state
      measure(32'h7d00, regVal[3], 32'h0, regVal[5]);
      access(1'b1, 7'h40, 32'h1c5); // stop settings still zero
      measure(32'h0, 32'h0, 32'h0, 32'h0);
      access(1'b1, 7'h44, 32'h3e80);
      access(1'b1, 7'h48, regVal[3]);
      measure(32'h3e80, regVal[3], 32'h0, 32'h0);
      access(1'b1, 7'h40, 32'h1);
      outs(1'b0, 1'b0);
      access(1'b1, 7'h40, 32'h10);
      outs(1'b1, 1'b0);
      access(1'b1, 7'h40, 32'h20);
      outs(1'b0, 1'b1);
      access(1'b1, 7'h40, 32'h22);
      countOne <= 32'h63;
      outs(1'b0, 1'b1);
      countOne <= 32'h64;
      outs(1'b1, 1'b1);
      access(1'b0, 7'h70, 32'h0);
      `CHECK("status", 32'h3, rd)
      access(1'b1, 7'h40, 32'h8);
      countTwo <= 32'h32;
      outs(1'b0, 1'b1);
      countTwo <= 32'h31;
      outs(1'b0, 1'b0);
      access(1'b0, 7'h68, 32'h0);
      `CHECK("accumulator three", countThree, rd)
      access(1'b1, 7'h40, 32'h2);
      countOne <= 32'hc8;
      outs(1'b1, 1'b0);
      access(1'b1, 7'h54, 32'h1);
      outs(1'b0, 1'b0);
      access(1'b1, 7'h54, 32'h2);
      @(posedge ref_clk);
      `CHECK("clears one", 1, clrOneSeen)
      `CHECK("clears three", 1, clrThreeSeen)
      byteenable <= 4'h2;
      access(1'b1, 7'h0c, 32'hffffffff);
      byteenable <= 4'hf;
      access(1'b0, 7'h0c, 32'h0);
      `CHECK("byte merge", 32'hff64, rd)
      access(1'b1, 7'h00, 32'hffffffff);
      access(1'b0, 7'h00, 32'h0);
      `CHECK("unmapped read", 32'h0, rd)
      printVerdict();
   end
endmodule : dual_output_pwm_compare_tb

bind dual_output_pwm_compare pwm_compare_checker #(.CLK_HZ(CLK_HZ)) chk (.ref_clk(ref_clk),
   .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .counterOneCount(counterOneCount), .outputChannelOne(outputChannelOne),
   .counterOneClear(counterOneClear), .counterThreeClear(counterThreeClear));
`default_nettype wire
